// [rtl/port_cfg_regs.svh]
// Register map, field layouts, reset values and bus response codes for the port pin block
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef PORT_CFG_REGS_SVH
`define PORT_CFG_REGS_SVH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define OFS_PORT_DATA   8'h00
`define OFS_PIN_DIR     8'h04
`define OFS_DRIVE_SEL   8'h08
`define OFS_PULL_EN     8'h0c
`define OFS_PULL_POL    8'h10
`define OFS_RESERVED    8'h14
`define OFS_ROUTING     8'h18

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define ROUTE_MASK      8'h31
`define CFG_RESET       8'h00
`define RESERVED_VALUE  8'h00
`define PIN_PWM0        0
`define PIN_PWM4        4
`define PIN_PWM5        5
`define PIN_CLKOUT      5

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// [rtl/port_cfg_pkg.sv]
// Types shared by the port pin block
// Assumes the register header is included by the modules that need numbers
package port_cfg_pkg;

  // --------------------------------------------------------------------------
  // Bus state machines
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_e;

  // Register selector after address decode
  typedef enum logic [2:0] {
    SEL_DATA  = 3'h0,
    SEL_DIR   = 3'h1,
    SEL_DRIVE = 3'h2,
    SEL_PULL  = 3'h3,
    SEL_POL   = 3'h4,
    SEL_RSVD  = 3'h5,
    SEL_ROUTE = 3'h6,
    SEL_NONE  = 3'h7
  } reg_sel_e;

endpackage : port_cfg_pkg

// [rtl/pin_force_mux.sv]
// Per-pin output source selection and direction forcing for an 8-bit port
// Assumes all inputs are on the bus clock; purely combinational
`include "port_cfg_regs.svh"

module pin_force_mux
  import port_cfg_pkg::*;
(
  input  wire logic [7:0] pin_direction,
  input  wire logic [7:0] port_data,
  input  wire logic [7:0] timer_oc_en,
  input  wire logic [7:0] timer_oc_out,
  input  wire logic [7:0] pwm_local_en,
  input  wire logic [7:0] pwm_local_out,
  input  wire logic       clk_out_en,
  input  wire logic       clk_out,
  output logic      [7:0] pin_is_output,
  output logic      [7:0] pin_value
);

  logic [7:0] clk_en_vec;
  logic [7:0] clk_val_vec;

  // Periodic clock only reaches its one pin
  assign clk_en_vec  = clk_out_en ? (8'h01 << `PIN_CLKOUT) : 8'h00;
  assign clk_val_vec = clk_out ? (8'h01 << `PIN_CLKOUT) : 8'h00;

  // Priority: timer, then routed pulse width, then clock, then register
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      always_comb
      begin
        pin_is_output[i] = pin_direction[i] | timer_oc_en[i]
                         | pwm_local_en[i] | clk_en_vec[i];
        if (timer_oc_en[i])
          pin_value[i] = timer_oc_out[i];
        else if (pwm_local_en[i])
          pin_value[i] = pwm_local_out[i];
        else if (clk_en_vec[i])
          pin_value[i] = clk_val_vec[i];
        else
          pin_value[i] = port_data[i];
      end
    end
  endgenerate

endmodule : pin_force_mux

// [rtl/port_t_pin_config.sv]
// Pin configuration block for an 8-bit general purpose port
// Assumes an AXI4-Lite master on aclk and pad cells that resolve the pin
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`include "port_cfg_regs.svh"

module port_t_pin_config
  import port_cfg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [7:0]  timer_oc_en,
  input  wire logic [7:0]  timer_oc_out,
  input  wire logic [2:0]  pwm_en,
  input  wire logic [2:0]  pwm_out,
  input  wire logic        clk_out_en,
  input  wire logic        clk_out,
  input  wire logic [7:0]  pad_in,
  output logic [7:0]       pad_out,
  output logic [7:0]       pad_oe_n,
  output logic [7:0]       pad_reduced_drive,
  output logic [7:0]       pad_pull_en,
  output logic [7:0]       pad_pull_down,
  output logic [2:0]       alt_pwm_en,
  output logic [2:0]       alt_pwm_out
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0] port_data_register;
  logic [7:0] pin_direction;
  logic [7:0] drive_strength_select;
  logic [7:0] pull_enable;
  logic [7:0] pull_polarity;
  logic [7:0] channel_routing_select;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] pin_state;
  logic [7:0] pin_is_output;
  logic [7:0] pin_value;
  logic [7:0] pwm_local_en;
  logic [7:0] pwm_local_out;
  logic [2:0] route_here;
  wr_state_e  wr_state;
  rd_state_e  rd_state;
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic       w_lane0_q;
  logic       do_write;
  reg_sel_e   wr_sel;
  reg_sel_e   rd_sel_q;

  // Address decode shared by both bus paths
  function automatic reg_sel_e decode(input logic [7:0] addr);
    unique case (addr)
      `OFS_PORT_DATA: decode = SEL_DATA;
      `OFS_PIN_DIR:   decode = SEL_DIR;
      `OFS_DRIVE_SEL: decode = SEL_DRIVE;
      `OFS_PULL_EN:   decode = SEL_PULL;
      `OFS_PULL_POL:  decode = SEL_POL;
      `OFS_RESERVED:  decode = SEL_RSVD;
      `OFS_ROUTING:   decode = SEL_ROUTE;
      default:        decode = SEL_NONE;
    endcase
  endfunction : decode

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  // Address and data taken in either order, then one write and a response
  assign awready  = (wr_state == WR_IDLE) && !aw_held;
  assign wready   = (wr_state == WR_IDLE) && !w_held;
  assign do_write = (wr_state == WR_IDLE) && aw_held && w_held;
  assign wr_sel   = decode(aw_addr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (wvalid && wready)
      begin
        w_held    <= 1'b1;
        w_data_q  <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Response state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state <= WR_IDLE;
      bresp    <= `RESP_OKAY;
    end
    else
    begin
      unique case (wr_state)
        WR_IDLE:
          if (do_write)
          begin
            wr_state <= WR_RESP;
            bresp    <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
          end
        WR_RESP:
          if (bready)
            wr_state <= WR_IDLE;
        default:
          wr_state <= WR_IDLE;
      endcase
    end
  end

  assign bvalid = (wr_state == WR_RESP);

  // Configuration registers, writable at any time; reserved slot ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_data_register     <= `CFG_RESET;
      pin_direction          <= `CFG_RESET;
      drive_strength_select  <= `CFG_RESET;
      pull_enable            <= `CFG_RESET;
      pull_polarity          <= `CFG_RESET;
      channel_routing_select <= `CFG_RESET;
    end
    else if (do_write && w_lane0_q)
    begin
      unique case (wr_sel)
        SEL_DATA:  port_data_register     <= w_data_q;
        SEL_DIR:   pin_direction          <= w_data_q;
        SEL_DRIVE: drive_strength_select  <= w_data_q;
        SEL_PULL:  pull_enable            <= w_data_q;
        SEL_POL:   pull_polarity          <= w_data_q;
        SEL_ROUTE: channel_routing_select <= w_data_q & `ROUTE_MASK;
        default:   ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  assign arready = (rd_state == RD_IDLE);
  assign rvalid  = (rd_state == RD_DATA);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state <= RD_IDLE;
      rd_sel_q <= SEL_NONE;
      rdata    <= 32'h0000_0000;
      rresp    <= `RESP_OKAY;
    end
    else
    begin
      unique case (rd_state)
        RD_IDLE:
          if (arvalid)
          begin
            rd_state <= RD_DATA;
            rd_sel_q <= decode(araddr);
            rresp    <= (decode(araddr) == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            unique case (decode(araddr))
              SEL_DATA:  rdata <= {24'h000000,
                                   (pin_direction & port_data_register)
                                   | (~pin_direction & pin_state)};
              SEL_DIR:   rdata <= {24'h000000, pin_direction};
              SEL_DRIVE: rdata <= {24'h000000, drive_strength_select};
              SEL_PULL:  rdata <= {24'h000000, pull_enable};
              SEL_POL:   rdata <= {24'h000000, pull_polarity};
              SEL_ROUTE: rdata <= {24'h000000, channel_routing_select};
              SEL_RSVD:  rdata <= {24'h000000, `RESERVED_VALUE};
              default:   rdata <= 32'h0000_0000;
            endcase
          end
        RD_DATA:
          if (rready)
            rd_state <= RD_IDLE;
        default:
          rd_state <= RD_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pin input buffer
  // --------------------------------------------------------------------------
  // Three stages; a bit changes once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1     <= 8'h00;
      sync2     <= 8'h00;
      sync3     <= 8'h00;
      pin_state <= 8'h00;
    end
    else
    begin
      sync1     <= pad_in;
      sync2     <= sync1;
      sync3     <= sync2;
      pin_state <= (sync2 & sync3) | (pin_state & (sync2 ^ sync3));
    end
  end

  // --------------------------------------------------------------------------
  // Pulse width routing and output forcing
  // --------------------------------------------------------------------------
  // Channel 0, 1, 2 map to pins 0, 4, 5
  assign route_here = {channel_routing_select[`PIN_PWM5],
                       channel_routing_select[`PIN_PWM4],
                       channel_routing_select[`PIN_PWM0]};
  assign alt_pwm_en  = pwm_en & ~route_here;
  assign alt_pwm_out = pwm_out & ~route_here;

  always_comb
  begin
    pwm_local_en                 = 8'h00;
    pwm_local_out                = 8'h00;
    pwm_local_en[`PIN_PWM0]      = pwm_en[0] & route_here[0];
    pwm_local_en[`PIN_PWM4]      = pwm_en[1] & route_here[1];
    pwm_local_en[`PIN_PWM5]      = pwm_en[2] & route_here[2];
    pwm_local_out[`PIN_PWM0]     = pwm_out[0];
    pwm_local_out[`PIN_PWM4]     = pwm_out[1];
    pwm_local_out[`PIN_PWM5]     = pwm_out[2];
  end

  pin_force_mux u_force (
    .pin_direction (pin_direction),
    .port_data     (port_data_register),
    .timer_oc_en   (timer_oc_en),
    .timer_oc_out  (timer_oc_out),
    .pwm_local_en  (pwm_local_en),
    .pwm_local_out (pwm_local_out),
    .clk_out_en    (clk_out_en),
    .clk_out       (clk_out),
    .pin_is_output (pin_is_output),
    .pin_value     (pin_value)
  );

  // Pad controls; enable low while driving
  assign pad_out           = pin_value;
  assign pad_oe_n          = ~pin_is_output;
  assign pad_reduced_drive = drive_strength_select & pin_is_output;
  assign pad_pull_en       = pull_enable & ~pin_is_output;
  assign pad_pull_down     = pull_polarity & pad_pull_en;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  AST_PLAIN_DIRECTION: assert property (@(posedge aclk) disable iff (!aresetn)
    (pad_oe_n[2] == ~(pin_direction[2] | timer_oc_en[2])))
    else $error("Pin 2 direction does not follow its bit");

  AST_TIMER_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_oc_en[7] |-> (!pad_oe_n[7] && pad_out[7] == timer_oc_out[7]))
    else $error("Timer compare did not force pin 7");

  AST_PIN5_PRIORITY: assert property (@(posedge aclk) disable iff (!aresetn)
    (!timer_oc_en[5] && !(pwm_en[2] && channel_routing_select[5]) && clk_out_en)
    |-> (!pad_oe_n[5] && pad_out[5] == clk_out))
    else $error("Clock output not on pin 5 when it should be");

  AST_PIN0_PWM: assert property (@(posedge aclk) disable iff (!aresetn)
    (!timer_oc_en[0] && pwm_en[0] && channel_routing_select[0])
    |-> (!pad_oe_n[0] && pad_out[0] == pwm_out[0]))
    else $error("Routed pulse width not on pin 0");

  AST_DIR_KEPT: assert property (@(posedge aclk) disable iff (!aresetn)
    !(do_write && wr_sel == SEL_DIR) |=> $stable(pin_direction))
    else $error("Direction bits changed without a write");

  AST_REDUCED_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    pad_reduced_drive == (drive_strength_select & ~pad_oe_n))
    else $error("Reduced drive mismatch");

  AST_PULL_INPUT: assert property (@(posedge aclk) disable iff (!aresetn)
    pad_pull_en == (pull_enable & pad_oe_n))
    else $error("Pull enable mismatch");

  AST_PULL_POLARITY: assert property (@(posedge aclk) disable iff (!aresetn)
    pad_pull_down == (pull_polarity & pull_enable & pad_oe_n))
    else $error("Pull-down does not follow polarity and enable");

  AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && rd_sel_q == SEL_RSVD) |-> (rdata == 32'h0000_0000))
    else $error("Reserved register read non-zero");

  AST_WRITE_ANYTIME: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && w_lane0_q && wr_sel == SEL_PULL)
    |=> (pull_enable == $past(w_data_q)))
    else $error("Pull enable write lost");

  AST_ROUTE_AWAY: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwm_en[1] && !channel_routing_select[4]) |-> (alt_pwm_en[1] && pad_oe_n[4]
      == ~(pin_direction[4] | timer_oc_en[4])))
    else $error("Channel 1 not steered to alternate pin");

  AST_RESET_ZERO: assert property (@(posedge aclk)
    !aresetn |=> (pin_direction == 8'h00 && pull_enable == 8'h00
      && drive_strength_select == 8'h00 && pull_polarity == 8'h00))
    else $error("Configuration not zero after reset");

endmodule : port_t_pin_config

// [verification/pin_board_model.sv]
// Board model around the port pins: drivers, pull devices, floating pins
// Assumes pad outputs settle combinationally on the block's clock
module pin_board_model
(
  input  wire logic       aclk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pad_pull_en,
  input  wire logic [7:0] pad_pull_down,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] float_pat = 8'h55;

  // Undriven, unpulled pins wander every cycle
  always @(posedge aclk)
    float_pat <= ~float_pat;

  // Port driver first, then a board driver, then the pull device
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!pad_oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pull_en[i])
        pad_in[i] = ~pad_pull_down[i];
      else
        pad_in[i] = float_pat[i];
    end
  end
endmodule : pin_board_model

// [verification/port_t_pin_config_tb.sv]
// Self-checking bench for the port pin configuration block
// Assumes the register header offsets and a 100 MHz bus clock
`include "port_cfg_regs.svh"

module port_t_pin_config_tb;
  import port_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0] dir, toc_en, toc_out;
    logic [2:0] pwm_en, pwm_out;
    logic       ck_en, ck;
    logic [7:0] route, oe_n, out;
    logic [2:0] alt;
  } row_s;

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn;
  logic [7:0]  awaddr, araddr, timer_oc_en, timer_oc_out, pad_in, pad_out, pad_oe_n;
  logic [7:0]  pad_reduced_drive, pad_pull_en, pad_pull_down, ext_en, ext_val;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, clk_out_en, clk_out;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pwm_en, pwm_out, alt_pwm_en, alt_pwm_out;
  int          n_mismatch = 0;
  int          n_tests = 0;
  logic [7:0]  d;
  logic [1:0]  r;
  logic [7:0]  ofs [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  row_s        rows [8] = '{
    '{8'h00, 8'h00, 8'h00, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 8'hff, 8'h00, 3'h0},
    '{8'hff, 8'h00, 8'h00, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 8'h00, 8'ha5, 3'h0},
    '{8'h00, 8'hce, 8'h4a, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 8'h31, 8'h4a, 3'h0},
    '{8'h00, 8'h00, 8'h00, 3'h7, 3'h5, 1'b1, 1'b0, 8'h31, 8'hce, 8'h21, 3'h0},
    '{8'h00, 8'h00, 8'h00, 3'h7, 3'h5, 1'b1, 1'b0, 8'h00, 8'hdf, 8'h00, 3'h7},
    '{8'h00, 8'h31, 8'h00, 3'h7, 3'h7, 1'b1, 1'b1, 8'h31, 8'hce, 8'h00, 3'h0},
    '{8'h00, 8'h00, 8'h00, 3'h4, 3'h0, 1'b1, 1'b1, 8'h31, 8'hdf, 8'h00, 3'h0},
    '{8'h01, 8'h00, 8'h00, 3'h0, 3'h0, 1'b1, 1'b1, 8'h00, 8'hde, 8'h21, 3'h0}};

  always #5 aclk = ~aclk;

  port_t_pin_config u_port_t_pin_config (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer_oc_en(timer_oc_en), .timer_oc_out(timer_oc_out),
    .pwm_en(pwm_en), .pwm_out(pwm_out), .clk_out_en(clk_out_en),
    .clk_out(clk_out), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_reduced_drive(pad_reduced_drive), .pad_pull_en(pad_pull_en),
    .pad_pull_down(pad_pull_down), .alt_pwm_en(alt_pwm_en),
    .alt_pwm_out(alt_pwm_out));

  pin_board_model u_pin_board_model (.aclk(aclk), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en),
    .pad_pull_down(pad_pull_down), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  // Bounded wait step; a used-up limit ends the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50)
    begin
      n_mismatch++;
      results();
    end
  endtask : tick

  task automatic axi_write(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
    int   n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      tick(n);
      aw_done = aw_done | awready;
      w_done = w_done | wready;
      if (aw_done)
        awvalid <= 1'b0;
      if (w_done)
        wvalid <= 1'b0;
    end
    do
      tick(n);
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [7:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      tick(n);
    while (!arready);
    arvalid <= 1'b0;
    do
      tick(n);
    while (!rvalid);
    v = rdata[7:0];
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] rs;
    axi_write(a, v, rs);
  endtask : wr

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    {awaddr, araddr, timer_oc_en, timer_oc_out, ext_en, ext_val} = '0;
    {awvalid, wvalid, bready, arvalid, rready, clk_out_en, clk_out} = '0;
    {wdata, wstrb, pwm_en, pwm_out} = '0;
    aresetn = 1'b0;
    do_reset();
    foreach (ofs[i])
    begin
      axi_read(ofs[i], d, r);
      chk_val(d, 8'h00);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      wr(ofs[i], 8'h5a ^ 8'(i * 8'h33));
      axi_read(ofs[i], d, r);
      chk_val(d, 8'h5a ^ 8'(i * 8'h33));
    end
    axi_write(`OFS_RESERVED, 8'hff, r);
    chk_resp(r, `RESP_OKAY);
    axi_read(`OFS_RESERVED, d, r);
    chk_val(d, 8'h00);
    axi_write(8'h1c, 8'hff, r);
    chk_resp(r, `RESP_SLVERR);
    axi_read(8'h1c, d, r);
    chk_resp(r, `RESP_SLVERR);
    $display("test register access done");
    wr(`OFS_PORT_DATA, 8'ha5);
    for (int i = 0; i < 8; i++)
    begin
      wr(`OFS_PIN_DIR, rows[i].dir);
      wr(`OFS_ROUTING, rows[i].route);
      timer_oc_en <= rows[i].toc_en;
      timer_oc_out <= rows[i].toc_out;
      pwm_en <= rows[i].pwm_en;
      pwm_out <= rows[i].pwm_out;
      clk_out_en <= rows[i].ck_en;
      clk_out <= rows[i].ck;
      @(posedge aclk);
      #1;
      chk_val(pad_oe_n, rows[i].oe_n);
      chk_val(pad_out & ~rows[i].oe_n, rows[i].out);
      chk_val({5'h0, alt_pwm_en}, {5'h0, rows[i].alt});
      chk_val({5'h0, alt_pwm_out}, {5'h0, rows[i].alt & rows[i].pwm_out});
      axi_read(`OFS_PIN_DIR, d, r);
      chk_val(d, rows[i].dir);
    end
    $display("test direction forcing done");
    @(posedge aclk);
    {timer_oc_en, pwm_en, clk_out_en} <= '0;
    wr(`OFS_PIN_DIR, 8'hf0);
    wr(`OFS_DRIVE_SEL, 8'hff);
    wr(`OFS_PULL_EN, 8'hff);
    wr(`OFS_PULL_POL, 8'h0f);
    #1;
    chk_val(pad_reduced_drive, 8'hf0);
    chk_val(pad_pull_en, 8'h0f);
    chk_val(pad_pull_down, 8'h0f);
    @(posedge aclk);
    timer_oc_en <= 8'h01;
    @(posedge aclk);
    #1;
    chk_val(pad_reduced_drive, 8'hf1);
    chk_val(pad_pull_en, 8'h0e);
    chk_val(pad_pull_down, 8'h0e);
    $display("test drive and pull done");
    @(posedge aclk);
    timer_oc_en <= 8'h00;
    wr(`OFS_PIN_DIR, 8'h0f);
    repeat (5) @(posedge aclk);
    axi_read(`OFS_PORT_DATA, d, r);
    chk_val(d, 8'hf5);
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    repeat (5) @(posedge aclk);
    axi_read(`OFS_PORT_DATA, d, r);
    chk_val(d, 8'h35);
    $display("test data read done");
    do_reset();
    @(posedge aclk);
    #1;
    chk_val(pad_oe_n, 8'hff);
    axi_read(`OFS_PULL_EN, d, r);
    chk_val(d, 8'h00);
    $display("test second reset done");
    results();
  end
endmodule : port_t_pin_config_tb
